// file: hdl/ism_defs.svh
`ifndef ISM_DEFS_SVH
`define ISM_DEFS_SVH

// ****************************************************************
// Register offsets (byte addresses, one 32-bit word each)
// ****************************************************************
`define ISM_OFS_LVL0      8'h00
`define ISM_OFS_LVL5      8'h14
`define ISM_OFS_STATUS    8'h18
`define ISM_OFS_CLEAR     8'h1C
`define ISM_OFS_ENABLE    8'h20
`define ISM_OFS_CURRENT   8'h24

// ****************************************************************
// Field positions
// ****************************************************************
`define ISM_LVL_FIELD_W   2
`define ISM_CUR_NUM_LSB   0
`define ISM_CUR_LVL_LSB   8
`define ISM_CUR_VEC_LSB   12
`define ISM_CUR_PEND_BIT  31

// ****************************************************************
// Reset values
// ****************************************************************
`define ISM_LVL_RST       8'hFF
`define ISM_STATUS_RST    24'h000000
`define ISM_ENABLE_RST    24'h000000

// ****************************************************************
// Request numbering and vector table
// ****************************************************************
`define ISM_NUM_REQ       24
`define ISM_NUM_LVL_REG   6
`define ISM_VEC_FIRST     16'hFFFA
`define ISM_VEC_LAST      16'hFFCC
`define ISM_USED_MASK     24'hDD45FF

`endif

// file: hdl/ism_pkg.sv
package ism_pkg;

	// Two-bit level of one request
	typedef logic [1:0] ism_level_t;

	// Whole state of the source mapper
	typedef struct packed {
		logic                ack;
		logic [31:0]         rdData;
		logic [5:0][7:0]     levelReg;
		logic [23:0]         status;
		logic [23:0]         enable;
		logic                irqOut;
		logic                reqValid;
		logic [4:0]          reqNum;
		ism_level_t          reqLevel;
		logic [15:0]         vecUpper;
		logic [15:0]         vecLower;
	} ism_state_t;

endpackage : ism_pkg

// file: hdl/ism_prio_pick.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Fixed-order pick: lowest set index wins
// ****************************************************************
module ism_prio_pick #(
	parameter int N = 24,
	parameter int W = 5
) (
	// Candidate requests
	input  wire logic [N-1:0] reqVec,
	// Result
	output logic              found,
	output logic [W-1:0]      index
);

	// Scan downward so the lowest number is the last to overwrite
	always_comb begin
		found = 1'b0;
		index = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (reqVec[i]) begin
				found = 1'b1;
				index = W'(i);
			end
		end
	end

endmodule : ism_prio_pick

`default_nettype wire

// file: hdl/ism_source_mapper.sv
// Function
// - Vector upper byte at 0xFFFA minus twice the number, lower byte one above.
// - Each request has a two-bit level; four per level register, six registers.
// - Among equal-level pending requests the lowest number is served first.
// - Channels 2 and 6 share request 2, 3 and 7 share request 3.
// - Low-voltage detection and serial channel 0 share request 4.
// - Timer 0 lower/upper on 5/6, LIN receive/transmit on 7/8, timer 1 upper 14.
// - Bus 1 on 10, bus 0 on 16, converter 18, time-base 19, watch 20, more.
//
// The Wishbone interface to the registers and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "ism_defs.svh"

module ism_source_mapper
	import ism_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	// External interrupt channels
	input  wire logic        extIntCh2,
	input  wire logic        extIntCh3,
	input  wire logic        extIntCh4,
	input  wire logic        extIntCh5,
	input  wire logic        extIntCh6,
	input  wire logic        extIntCh7,
	// Peripheral sources
	input  wire logic        lowVoltageIrq,
	input  wire logic        asyncSyncSerialChannelIrq,
	input  wire logic        compTimer0LowerIrq,
	input  wire logic        compTimer0UpperIrq,
	input  wire logic        linUartRxIrq,
	input  wire logic        linUartTxIrq,
	input  wire logic        serialBus1Irq,
	input  wire logic        compTimer1UpperIrq,
	input  wire logic        serialBus0Irq,
	input  wire logic        converterIrq,
	input  wire logic        timeBaseIrq,
	input  wire logic        watchPrescalerIrq,
	input  wire logic        compTimer1LowerIrq,
	input  wire logic        flashIrq,
	// Towards the CPU core
	output logic             irqOut,
	output logic             reqValid,
	output logic [4:0]       reqNum,
	output logic [1:0]       reqLevel,
	output logic [15:0]      vecUpperAddr,
	output logic [15:0]      vecLowerAddr
);

	// ****************************************************************
	// Helper functions
	// ****************************************************************

	// Byte-lane merge for Wishbone select
	function automatic logic [31:0] laneMerge(input logic [31:0] oldVal,
			input logic [31:0] newVal, input logic [3:0] sel);
		logic [31:0] res;
		res = oldVal;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[8*b +: 8] = newVal[8*b +: 8];
			end
		end
		return res;
	endfunction : laneMerge

	// Upper vector byte address of a request
	function automatic logic [15:0] vecUpperOf(input logic [4:0] num);
		return `ISM_VEC_FIRST - {10'h000, num, 1'b0};
	endfunction : vecUpperOf

	// Level field of a request from its level register
	function automatic ism_level_t levelOf(input logic [5:0][7:0] regs,
			input int num);
		return regs[num / 4][`ISM_LVL_FIELD_W * (num % 4) +: `ISM_LVL_FIELD_W];
	endfunction : levelOf

	// ****************************************************************
	// State and reset value
	// ****************************************************************
	localparam ism_state_t STATE_RST = '{
		ack:      1'b0,
		rdData:   32'h0000_0000,
		levelReg: {`ISM_NUM_LVL_REG{`ISM_LVL_RST}},
		status:   `ISM_STATUS_RST,
		enable:   `ISM_ENABLE_RST,
		irqOut:   1'b0,
		reqValid: 1'b0,
		reqNum:   5'h00,
		reqLevel: 2'h0,
		vecUpper: `ISM_VEC_FIRST,
		vecLower: `ISM_VEC_FIRST + 16'h0001
	};

	ism_state_t st_r;
	ism_state_t st_nxt;

	// ****************************************************************
	// Source to request mapping
	// ****************************************************************
	logic [23:0] rawReq;
	logic [23:0] activeReq;

	// Peripheral flags are levels on sys_clk, so no synchroniser
	always_comb begin
		rawReq     = 24'h000000;
		rawReq[0]  = extIntCh4;
		rawReq[1]  = extIntCh5;
		rawReq[2]  = extIntCh2 | extIntCh6;
		rawReq[3]  = extIntCh3 | extIntCh7;
		rawReq[4]  = lowVoltageIrq | asyncSyncSerialChannelIrq;
		rawReq[5]  = compTimer0LowerIrq;
		rawReq[6]  = compTimer0UpperIrq;
		rawReq[7]  = linUartRxIrq;
		rawReq[8]  = linUartTxIrq;
		rawReq[10] = serialBus1Irq;
		rawReq[14] = compTimer1UpperIrq;
		rawReq[16] = serialBus0Irq;
		rawReq[18] = converterIrq;
		rawReq[19] = timeBaseIrq;
		rawReq[20] = watchPrescalerIrq;
		rawReq[22] = compTimer1LowerIrq;
		rawReq[23] = flashIrq;
		rawReq     = rawReq & `ISM_USED_MASK;
	end

	// Only enabled, latched requests compete
	assign activeReq = st_r.status & st_r.enable & `ISM_USED_MASK;

	// ****************************************************************
	// Level split and fixed-order pick
	// ****************************************************************
	logic [3:0][23:0] levelCand;
	logic [3:0]       levelFound;
	logic [3:0][4:0]  levelIdx;

	// Group the active requests by their level field
	always_comb begin
		levelCand = '0;
		for (int n = 0; n < `ISM_NUM_REQ; n++) begin
			levelCand[levelOf(st_r.levelReg, n)][n] = activeReq[n];
		end
	end

	// One pick per level; lowest number wins inside a level
	for (genvar l = 0; l < 4; l++) begin : g_pick
		ism_prio_pick #(
			.N (`ISM_NUM_REQ),
			.W (5)
		) u_pick (
			.reqVec (levelCand[l]),
			.found  (levelFound[l]),
			.index  (levelIdx[l])
		);
	end

	// Level 0 is the most urgent; the CPU masks against its own level
	logic       winValid;
	logic [4:0] winNum;
	ism_level_t winLevel;

	always_comb begin
		winValid = 1'b0;
		winNum   = 5'h00;
		winLevel = 2'h0;
		for (int l = 3; l >= 0; l--) begin
			if (levelFound[l]) begin
				winValid = 1'b1;
				winNum   = levelIdx[l];
				winLevel = ism_level_t'(l);
			end
		end
	end

	// ****************************************************************
	// Register read view
	// ****************************************************************
	logic [31:0] readMux;

	always_comb begin
		readMux = 32'h0000_0000;
		if (wb_adr_i[7:2] <= `ISM_OFS_LVL5 >> 2) begin
			readMux[7:0] = st_r.levelReg[wb_adr_i[4:2]];
		end else begin
			case (wb_adr_i)
				`ISM_OFS_STATUS: begin
					readMux[23:0] = st_r.status;
				end
				`ISM_OFS_ENABLE: begin
					readMux[23:0] = st_r.enable;
				end
				`ISM_OFS_CURRENT: begin
					readMux[`ISM_CUR_NUM_LSB +: 5]  = st_r.reqNum;
					readMux[`ISM_CUR_LVL_LSB +: 2]  = st_r.reqLevel;
					readMux[`ISM_CUR_VEC_LSB +: 16] = st_r.vecUpper;
					readMux[`ISM_CUR_PEND_BIT]      = st_r.reqValid;
				end
				default: begin
					// Clear register and unmapped words read zero
					readMux = 32'h0000_0000;
				end
			endcase
		end
	end

	// ****************************************************************
	// Next state
	// ****************************************************************
	logic        busReq;
	logic        busWrite;
	logic [31:0] clearMask;
	// Merged write words; a function result cannot be sliced in place
	logic [31:0] mergeLvl;
	logic [31:0] mergeEn;

	assign busReq   = wb_cyc_i & wb_stb_i;
	// Writes land on the edge where the master sees ack
	assign busWrite = busReq & wb_we_i & st_r.ack;

	always_comb begin
		st_nxt    = st_r;
		clearMask = 32'h0000_0000;

		// Both merges run every cycle; only the addressed one is stored.
		// Above the level words the level index is out of range or aliases a level word, unused.
		mergeLvl  = laneMerge({24'h000000, st_r.levelReg[wb_adr_i[4:2]]}, wb_dat_i,
			wb_sel_i);
		mergeEn   = laneMerge({8'h00, st_r.enable}, wb_dat_i, wb_sel_i);

		// Ack one cycle after the request, dropped the cycle after
		st_nxt.ack = busReq & ~st_r.ack;
		if (busReq & ~st_r.ack & ~wb_we_i) begin
			st_nxt.rdData = readMux;
		end

		// Software writes
		if (busWrite) begin
			if (wb_adr_i[7:2] <= `ISM_OFS_LVL5 >> 2) begin
				// Only byte 0 carries the four level fields
				st_nxt.levelReg[wb_adr_i[4:2]] = mergeLvl[7:0];
			end else if (wb_adr_i == `ISM_OFS_ENABLE) begin
				// Unsourced requests can never be enabled
				st_nxt.enable = mergeEn[23:0] & `ISM_USED_MASK;
			end else if (wb_adr_i == `ISM_OFS_CLEAR) begin
				clearMask = laneMerge(32'h0000_0000, wb_dat_i, wb_sel_i);
			end
		end

		// Sticky status: a source held high sets again over a clear,
		// so an event and a clear in one cycle leave the bit set
		st_nxt.status = (st_r.status & ~clearMask[23:0]) | rawReq;

		// CPU-facing outputs, registered from the current pick
		st_nxt.irqOut   = |activeReq;
		st_nxt.reqValid = winValid;
		st_nxt.reqNum   = winNum;
		st_nxt.reqLevel = winLevel;
		st_nxt.vecUpper = vecUpperOf(winNum);
		st_nxt.vecLower = vecUpperOf(winNum) + 16'h0001;
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= STATE_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign wb_ack_o     = st_r.ack;
	assign wb_dat_o     = st_r.rdData;
	assign irqOut       = st_r.irqOut;
	assign reqValid     = st_r.reqValid;
	assign reqNum       = st_r.reqNum;
	assign reqLevel     = st_r.reqLevel;
	assign vecUpperAddr = st_r.vecUpper;
	assign vecLowerAddr = st_r.vecLower;

endmodule : ism_source_mapper

`default_nettype wire

// file: tb/ism_monitor.sv
`timescale 1ns/10ps
`default_nettype none
`include "ism_defs.svh"
// ****************************************************************
// Port checker for the source mapper
// ****************************************************************
module ism_monitor (
	// Clock, reset and bus
	input wire logic        sys_clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	// CPU side
	input wire logic        irqOut, reqValid,
	input wire logic [4:0]  reqNum,
	input wire logic [15:0] vecUpperAddr, vecLowerAddr
);
	localparam logic [23:0] USED = `ISM_USED_MASK;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	// Request first seen, then a one-cycle answer
	sequence sReq; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
	sequence sAck; wb_ack_o ##1 !wb_ack_o; endsequence
	a_ack_answer: assert property (sReq |=> sAck)
		else $error("ack late or not a pulse");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	a_ack_idle: assert property (!wb_cyc_i ##1 !wb_cyc_i |-> !wb_ack_o)
		else $error("ack on idle bus");
	a_clear_reads: assert property (wb_ack_o && !wb_we_i && wb_adr_i == `ISM_OFS_CLEAR
		|-> wb_dat_o == 32'h0) else $error("clear register read not zero");
	a_vec_upper: assert property (vecUpperAddr == 16'hFFFA - {10'h0, reqNum, 1'b0})
		else $error("upper vector address wrong");
	a_vec_pair: assert property (vecLowerAddr == vecUpperAddr + 16'h1)
		else $error("lower vector address wrong");
	a_unused_quiet: assert property (reqValid |-> USED[reqNum])
		else $error("unsourced request served");
	a_irq_winner: assert property (irqOut |-> reqValid)
		else $error("interrupt with no winner");
endmodule : ism_monitor

bind ism_source_mapper ism_monitor mon (.sys_clk(sys_clk), .reset_n(reset_n),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o),
	.wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .irqOut(irqOut), .reqValid(reqValid),
	.reqNum(reqNum), .vecUpperAddr(vecUpperAddr), .vecLowerAddr(vecLowerAddr));
`default_nettype wire

// file: tb/ism_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// CPU core: fetches the vector pair while the line is high
// ****************************************************************
module ism_cpu_model (
	// Clock and reset
	input wire logic        sys_clk, reset_n,
	// From the mapper
	input wire logic        irqOut,
	input wire logic [15:0] vecUpperAddr, vecLowerAddr,
	// Last fetched upper address
	output logic [15:0]     fetchVec
);
	// Pair rejected unless lower byte sits one above
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			fetchVec <= 16'h0;
		else if (irqOut && vecLowerAddr == vecUpperAddr + 16'h1)
			fetchVec <= vecUpperAddr;
	end
endmodule : ism_cpu_model
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "ism_defs.svh"
module testbench import ism_pkg::*;;
	logic sys_clk, reset_n, wbCyc, wbStb, wbWe, wbAck, irqOut, reqValid;
	logic [7:0] wbAdr;
	logic [3:0] wbSel;
	logic [31:0] wbDat, wbDatO, rd;
	logic [19:0] src;
	logic [4:0] reqNum;
	logic [1:0] reqLevel;
	logic [15:0] vecU, vecL, fetchVec;
	int errors = 0;
	int samples_checked = 0;
	localparam logic [23:0] USED = `ISM_USED_MASK;
	// Request number each source bit should land on
	localparam int MAP[20] = '{2, 3, 0, 1, 2, 3, 4, 4, 5, 6, 7, 8, 10, 14, 16, 18, 19, 20, 22, 23};
	// Current word for request 23 at level 0: pending, vector, number
	localparam logic [31:0] CUR23 = (32'h1 << `ISM_CUR_PEND_BIT)
		| (32'hFFCC << `ISM_CUR_VEC_LSB) | 32'd23;

	ism_source_mapper dut (.sys_clk(sys_clk), .reset_n(reset_n), .wb_cyc_i(wbCyc),
		.wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat),
		.wb_dat_o(wbDatO), .wb_ack_o(wbAck), .extIntCh2(src[0]), .extIntCh3(src[1]),
		.extIntCh4(src[2]), .extIntCh5(src[3]), .extIntCh6(src[4]), .extIntCh7(src[5]),
		.lowVoltageIrq(src[6]), .asyncSyncSerialChannelIrq(src[7]),
		.compTimer0LowerIrq(src[8]), .compTimer0UpperIrq(src[9]), .linUartRxIrq(src[10]),
		.linUartTxIrq(src[11]), .serialBus1Irq(src[12]), .compTimer1UpperIrq(src[13]),
		.serialBus0Irq(src[14]), .converterIrq(src[15]), .timeBaseIrq(src[16]),
		.watchPrescalerIrq(src[17]), .compTimer1LowerIrq(src[18]), .flashIrq(src[19]),
		.irqOut(irqOut), .reqValid(reqValid), .reqNum(reqNum), .reqLevel(reqLevel),
		.vecUpperAddr(vecU), .vecLowerAddr(vecL));
	ism_cpu_model cpu (.sys_clk(sys_clk), .reset_n(reset_n), .irqOut(irqOut),
		.vecUpperAddr(vecU), .vecLowerAddr(vecL), .fetchVec(fetchVec));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Classic cycle; waits for ack, only the watchdog ends a hang
	task automatic wbXfer(input logic we, input logic [7:0] a, input logic [31:0] d);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= a;
		wbDat <= d;
		do begin
			@(posedge sys_clk);
		end while (wbAck !== 1'b1);
		rd = wbDatO;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		wbWe <= 1'b0;
		@(posedge sys_clk);
		chk("ack drop", 32'h0, wbAck);
	endtask : wbXfer

	task automatic expectWin(input int n, input logic [1:0] lvl);
		chk("request number", n, reqNum);
		chk("upper vector", 32'hFFFA - 2 * n, vecU);
		chk("lower vector", 32'hFFFB - 2 * n, vecL);
		chk("level", lvl, reqLevel);
		chk("irq line", 32'h1, irqOut);
		chk("pending flag", 32'h1, reqValid);
	endtask : expectWin

	task complete_run;
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : complete_run

	initial begin
		{reset_n, wbCyc, wbStb, wbWe, wbAdr, wbDat, src} = '0;
		wbSel = 4'hF;
		repeat (12) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		// Reset values, unmapped place, enable read-back
		wbXfer(1'b0, `ISM_OFS_LVL5, 32'h0);
		chk("level reg 5", 32'hFF, rd);
		wbXfer(1'b0, 8'h40, 32'h0);
		chk("unmapped", 32'h0, rd);
		wbXfer(1'b0, `ISM_OFS_CLEAR, 32'h0);
		chk("clear reads zero", 32'h0, rd);
		wbXfer(1'b1, `ISM_OFS_ENABLE, 32'hFFFFFF);
		wbXfer(1'b0, `ISM_OFS_ENABLE, 32'h0);
		chk("enable", USED, rd);
		// Each source alone, shared ones included
		foreach (MAP[i]) begin
			src <= 20'h1 << i;
			repeat (3) @(posedge sys_clk);
			expectWin(MAP[i], 2'h3);
			wbXfer(1'b0, `ISM_OFS_STATUS, 32'h0);
			chk("status", 32'h1 << MAP[i], rd);
			chk("fetched vector", 32'hFFFA - 2 * MAP[i], fetchVec);
			src <= '0;
			wbXfer(1'b1, `ISM_OFS_CLEAR, 32'h1 << MAP[i]);
		end
		// All pending at equal level: served in number order
		src <= '1;
		repeat (3) @(posedge sys_clk);
		wbXfer(1'b0, `ISM_OFS_STATUS, 32'h0);
		chk("status all", USED, rd);
		for (int n = 0; n < 24; n++) if (USED[n]) begin
			repeat (3) @(posedge sys_clk);
			expectWin(n, 2'h3);
			foreach (MAP[i]) if (MAP[i] == n) src[i] <= 1'b0;
			wbXfer(1'b1, `ISM_OFS_CLEAR, 32'h1 << n);
		end
		// Last request made most urgent beats request 0
		wbXfer(1'b1, `ISM_OFS_LVL5, 32'h3F);
		src <= 20'h80004;
		repeat (3) @(posedge sys_clk);
		expectWin(23, 2'h0);
		@(posedge sys_clk);
		chk("fetched vector", 32'hFFCC, fetchVec);
		wbXfer(1'b0, `ISM_OFS_CURRENT, 32'h0);
		chk("current word", CUR23, rd);
		// Masking drops the line but keeps status
		wbXfer(1'b1, `ISM_OFS_ENABLE, 32'h0);
		@(posedge sys_clk);
		chk("masked line", 32'h0, irqOut);
		wbXfer(1'b0, `ISM_OFS_STATUS, 32'h0);
		chk("masked status", 32'h800001, rd);
		// Reset in mid-run returns the irq line, pending flag, both vectors, level register 5 and enable to their reset values
		src <= '0;
		reset_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		chk("reset irq line", 32'h0, irqOut);
		chk("reset pending", 32'h0, reqValid);
		chk("reset upper vector", `ISM_VEC_FIRST, vecU);
		chk("reset lower vector", 32'hFFFB, vecL);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		wbXfer(1'b0, `ISM_OFS_LVL5, 32'h0);
		chk("level reg 5 reset", `ISM_LVL_RST, rd);
		wbXfer(1'b0, `ISM_OFS_ENABLE, 32'h0);
		chk("enable reset", 32'h0, rd);
		complete_run;
	end

	// Watchdog, far beyond the few hundred cycles needed
	initial begin
		#100000;
		errors++;
		complete_run;
	end
endmodule : testbench
`default_nettype wire
